// File: hw/event_irq_map.vh
// Register offsets, field positions and reset values of the event flag block
`ifndef EVENT_IRQ_MAP_VH
`define EVENT_IRQ_MAP_VH

// Register offsets
`define EVT_FLAGS_ADDR       8'h00
`define EVT_MASK_ADDR        8'h01

// Field positions, shared by flag and mask registers
`define BIT_POWER_LOSS       7
`define BIT_WAKE             6
`define BIT_AUX_FAULT        5
`define BIT_LINE_FAULT       4
`define BIT_SUPPLY_WARN      3
`define BIT_SUPPLY_UV        2
`define BIT_UNUSED           1
`define BIT_OVERTEMP         0

// Position of the logic-supply lockout input in the synchronised vector
`define SYNC_LOGIC_UVLO      1
// Position of the external corruption input in the synchronised vector
`define SYNC_CORRUPT         7

// Reset values
`define EVT_FLAGS_RST        8'h80
`define EVT_MASK_RST         8'h00

// Implemented bits
`define EVT_FLAGS_USED       8'hfd
`define EVT_MASK_WMASK       8'h7d

// Width of the synchronised event vector, one bit per async cause
`define SYNC_WIDTH           8

`endif

// File: hw/event_sync.v
// Two-stage synchroniser for the asynchronous event inputs
`timescale 1ns/1ps

`include "event_irq_map.vh"

module event_sync (
    input  wire                    i_mclk,
    input  wire                    i_rst,
    input  wire [`SYNC_WIDTH-1:0]  i_async,
    output reg  [`SYNC_WIDTH-1:0]  o_sync
);

    reg [`SYNC_WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            meta_q <= {`SYNC_WIDTH{1'b0}};
            o_sync <= {`SYNC_WIDTH{1'b0}};
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end

endmodule

// File: hw/event_flag_irq_logic.v
// Event flag register, interrupt mask register and active-low interrupt
//
// Operation
// - Unmasked set flag drives interrupt low
// - Flag read clears flags once cause gone
// - Power-loss flag reads 1 after reset
// - Logic supply lockout resets, sets power-loss
// - Register corruption sets power-loss flag
// - Power-loss flag is never masked
// - Bit 6 latches wake-up detection
// - Bit 5 latches auxiliary driver fault
// - Bit 4 latches line driver fault
// - Bit 3 latches field supply warning
// - Bit 2 only with regulator off, undervoltage
// - Undervoltage, regulator on: internal reset, sets power-loss
// - Bit 0 latches overtemperature warning
// - Set mask bit blocks that flag's interrupt
// - Mask never stops a flag latching
// - Mask bits share their flag's position
`timescale 1ns/1ps

`include "event_irq_map.vh"

module event_flag_irq_logic (
    input  wire        i_mclk,
    input  wire        i_rst,
    // Condition inputs from analog comparators, asynchronous
    input  wire        i_wake_det,
    input  wire        i_aux_fault,
    input  wire        i_line_fault,
    input  wire        i_supply_warn,
    input  wire        i_supply_uv,
    input  wire        i_overtemp,
    input  wire        i_logic_uvlo,
    input  wire        i_reg_corrupt,
    // Regulator disable from the mode register, same clock
    input  wire        i_regulator_off,
    // Register access port from the serial interface, same clock
    input  wire [7:0]  i_reg_addr,
    input  wire        i_reg_wr,
    input  wire        i_reg_rd,
    input  wire [7:0]  i_reg_wdata,
    output reg  [7:0]  o_reg_rdata,
    output reg         o_reg_ack,
    output reg         o_reg_err,
    // Interrupt and internal reset
    output reg         o_irq_n,
    output reg         o_int_rst,
    output reg  [7:0]  o_event_mask
);

    // Even parity of a byte
    function par8;
        input [7:0] v;
        begin
            par8 = ^v;
        end
    endfunction

    // Flags allowed onto the interrupt; power-loss has no mask
    function [7:0] irq_gate;
        input [7:0] flags;
        input [7:0] mask;
        reg   [7:0] en;
        begin
            en = ~(mask & `EVT_MASK_WMASK);
            en[`BIT_POWER_LOSS] = 1'b1;
            irq_gate = flags & en & `EVT_FLAGS_USED;
        end
    endfunction

    // Address decode of one register
    function hit;
        input [7:0] addr;
        input [7:0] offset;
        begin
            hit = (addr == offset);
        end
    endfunction

    wire [`SYNC_WIDTH-1:0] async_vec;
    wire [`SYNC_WIDTH-1:0] sync_vec;

    assign async_vec = {i_reg_corrupt,
                        i_wake_det,
                        i_aux_fault,
                        i_line_fault,
                        i_supply_warn,
                        i_supply_uv,
                        i_logic_uvlo,
                        i_overtemp};

    event_sync u_sync (
        .i_mclk  (i_mclk),
        .i_rst   (i_rst),
        .i_async (async_vec),
        .o_sync  (sync_vec)
    );

    reg  [7:0] flags_q;
    reg  [7:0] flags_d;
    reg  [7:0] mask_q;
    reg  [7:0] mask_d;
    reg        mask_par_q;
    reg        mask_par_d;
    reg  [7:0] set_vec;
    reg  [7:0] clr_vec;
    reg        uv_reset;
    reg        supply_reset;
    reg        mask_bad;
    reg        flag_rd;
    reg        mask_wr;
    reg        mapped;
    reg  [7:0] rdata_d;

    // Event set vector, independent of the mask
    always @* begin
        set_vec = 8'h00;
        set_vec[`BIT_WAKE]        = sync_vec[`BIT_WAKE];
        set_vec[`BIT_AUX_FAULT]   = sync_vec[`BIT_AUX_FAULT];
        set_vec[`BIT_LINE_FAULT]  = sync_vec[`BIT_LINE_FAULT];
        set_vec[`BIT_SUPPLY_WARN] = sync_vec[`BIT_SUPPLY_WARN];
        set_vec[`BIT_SUPPLY_UV]   = sync_vec[`BIT_SUPPLY_UV] &
                                    i_regulator_off;
        set_vec[`BIT_OVERTEMP]    = sync_vec[`BIT_OVERTEMP];
        // Mask held in flops can be upset; a parity slip counts as corrupt
        mask_bad = (par8(mask_q) != mask_par_q);
        set_vec[`BIT_POWER_LOSS]  = sync_vec[`SYNC_CORRUPT] |
                                    mask_bad;
    end

    // Register resets from the supplies act like a power-up reset
    always @* begin
        uv_reset     = sync_vec[`BIT_SUPPLY_UV] & ~i_regulator_off;
        supply_reset = uv_reset | sync_vec[`SYNC_LOGIC_UVLO];
    end

    // Access decode
    always @* begin
        flag_rd = i_reg_rd & hit(i_reg_addr, `EVT_FLAGS_ADDR);
        mask_wr = i_reg_wr & hit(i_reg_addr, `EVT_MASK_ADDR);
        mapped  = hit(i_reg_addr, `EVT_FLAGS_ADDR) |
                  hit(i_reg_addr, `EVT_MASK_ADDR);
    end

    // Flag update: a condition that persists sets again over the clear
    always @* begin
        clr_vec = flag_rd ? 8'hff : 8'h00;
        flags_d = ((flags_q & ~clr_vec) | set_vec) &
                  `EVT_FLAGS_USED;
        if (supply_reset) begin
            flags_d = `EVT_FLAGS_RST;
        end
    end

    // Mask update
    always @* begin
        mask_d = mask_q;
        if (mask_wr) begin
            mask_d = i_reg_wdata & `EVT_MASK_WMASK;
        end
        if (supply_reset || mask_bad) begin
            // A corrupted mask returns to its reset value
            mask_d = `EVT_MASK_RST;
        end
        mask_par_d = par8(mask_d);
    end

    // Read data mux; the flag value returned is the one before the clear
    always @* begin
        rdata_d = 8'h00;
        if (hit(i_reg_addr, `EVT_FLAGS_ADDR)) begin
            rdata_d = flags_q & `EVT_FLAGS_USED;
        end else if (hit(i_reg_addr, `EVT_MASK_ADDR)) begin
            rdata_d = mask_q & `EVT_MASK_WMASK;
        end
    end

    always @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            flags_q    <= `EVT_FLAGS_RST;
            mask_q     <= `EVT_MASK_RST;
            mask_par_q <= 1'b0;
        end else begin
            flags_q    <= flags_d;
            mask_q     <= mask_d;
            mask_par_q <= mask_par_d;
        end
    end

    // Outputs are registered; the interrupt follows the next flag state
    // so it changes on the same edge as the flags it reflects
    always @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_irq_n      <= 1'b0;
            o_int_rst    <= 1'b0;
            o_event_mask <= `EVT_MASK_RST;
            o_reg_rdata  <= 8'h00;
            o_reg_ack    <= 1'b0;
            o_reg_err    <= 1'b0;
        end else begin
            o_irq_n      <= ~|irq_gate(flags_d, mask_d);
            o_int_rst    <= uv_reset;
            o_event_mask <= mask_d;
            o_reg_ack    <= i_reg_rd | i_reg_wr;
            o_reg_err    <= (i_reg_rd | i_reg_wr) & ~mapped;
            if (i_reg_rd) begin
                o_reg_rdata <= rdata_d;
            end
        end
    end

endmodule

// File: verif/evt_irq_asserts.sv
// Port assertions for the event flag and interrupt block
`timescale 1ns/1ps
module evt_irq_asserts (
    input wire       i_mclk,
    input wire       i_rst,
    input wire       i_supply_uv,
    input wire       i_logic_uvlo,
    input wire       i_reg_corrupt,
    input wire       i_regulator_off,
    input wire [7:0] i_reg_addr,
    input wire       i_reg_wr,
    input wire       i_reg_rd,
    input wire [7:0] i_reg_wdata,
    input wire [7:0] o_reg_rdata,
    input wire       o_reg_err,
    input wire       o_irq_n,
    input wire       o_int_rst,
    input wire [7:0] o_event_mask
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    // Async causes are held three samples so the two sync stages have landed
    chk_unused_zero: assert property (
        (o_event_mask & 8'h82) == 8'h00)
        else $error("unused mask bit set");
    chk_mask_write: assert property (
        i_reg_wr && i_reg_addr == 8'h01
        |=> o_event_mask == ($past(i_reg_wdata) & 8'h7d))
        else $error("mask write not applied");
    chk_unmapped_rd: assert property (
        i_reg_rd && i_reg_addr > 8'h01
        |=> o_reg_err && o_reg_rdata == 8'h00)
        else $error("unmapped read not refused");
    chk_uv_reset: assert property (
        (i_supply_uv && !i_regulator_off)[*3] |=> o_int_rst)
        else $error("no internal reset on undervoltage");
    chk_uv_mask_clr: assert property (
        (i_supply_uv && !i_regulator_off)[*3] |=> o_event_mask == 8'h00)
        else $error("mask kept on undervoltage");
    chk_uvlo_irq: assert property (
        i_logic_uvlo[*3] |=> !o_irq_n)
        else $error("no interrupt on logic lockout");
    chk_uvlo_mask: assert property (
        i_logic_uvlo[*3] |=> o_event_mask == 8'h00)
        else $error("mask kept on logic lockout");
    chk_corrupt_irq: assert property (
        i_reg_corrupt[*3] |=> !o_irq_n)
        else $error("no interrupt on corruption");
endmodule

bind event_flag_irq_logic evt_irq_asserts u_chk (
    .i_mclk          (i_mclk),
    .i_rst           (i_rst),
    .i_supply_uv     (i_supply_uv),
    .i_logic_uvlo    (i_logic_uvlo),
    .i_reg_corrupt   (i_reg_corrupt),
    .i_regulator_off (i_regulator_off),
    .i_reg_addr      (i_reg_addr),
    .i_reg_wr        (i_reg_wr),
    .i_reg_rd        (i_reg_rd),
    .i_reg_wdata     (i_reg_wdata),
    .o_reg_rdata     (o_reg_rdata),
    .o_reg_err       (o_reg_err),
    .o_irq_n         (o_irq_n),
    .o_int_rst       (o_int_rst),
    .o_event_mask    (o_event_mask)
);

// File: verif/host_model.sv
// Host-side register access model for the event flag block
`timescale 1ns/1ps
module host_model (
    input  wire       i_mclk,
    input  wire [7:0] i_reg_rdata,
    input  wire       i_reg_ack,
    input  wire       i_reg_err,
    output reg  [7:0] o_reg_addr,
    output reg        o_reg_wr,
    output reg        o_reg_rd,
    output reg  [7:0] o_reg_wdata
);
    initial begin
        {o_reg_addr, o_reg_wr, o_reg_rd, o_reg_wdata} = 18'h0;
    end
    task xfer(input logic w, input logic [7:0] a, d,
              output logic [7:0] q, output logic ok, er);
        @(negedge i_mclk);
        {o_reg_addr, o_reg_wdata, o_reg_wr, o_reg_rd} = {a, d, w, !w};
        @(negedge i_mclk);
        {q, ok, er} = {i_reg_rdata, i_reg_ack, i_reg_err};
        // Released lines are scrambled so nothing leans on stale values
        {o_reg_addr, o_reg_wdata, o_reg_wr, o_reg_rd} = {~a, ~d, 2'b00};
    endtask
endmodule

// File: verif/tb_event_flag_irq_logic.sv
// Testbench for the event flag and interrupt block
`timescale 1ns/1ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin \
    n_mismatch++; $display("[ERR] %s exp %h got %h", n, e, a); end end
module tb_event_flag_irq_logic;
    reg         i_mclk, i_rst, reg_off;
    reg  [7:0]  ev;
    wire [7:0]  addr, wdata, rdata, mask;
    wire        wr, rd, ack, err, irq_n, int_rst;
    logic [7:0] q, bm;
    logic       ok, er;
    int         n_mismatch = 0, compares = 0;
    int         bits[6] = '{6, 5, 4, 3, 2, 0};
    event_flag_irq_logic DUT (.i_mclk(i_mclk), .i_rst(i_rst),
        .i_wake_det(ev[6]), .i_aux_fault(ev[5]), .i_line_fault(ev[4]),
        .i_supply_warn(ev[3]), .i_supply_uv(ev[2]), .i_overtemp(ev[0]),
        .i_logic_uvlo(ev[1]), .i_reg_corrupt(ev[7]),
        .i_regulator_off(reg_off), .i_reg_addr(addr), .i_reg_wr(wr),
        .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .o_reg_ack(ack), .o_reg_err(err), .o_irq_n(irq_n),
        .o_int_rst(int_rst), .o_event_mask(mask));
    host_model host (.i_mclk(i_mclk), .i_reg_rdata(rdata), .i_reg_ack(ack),
        .i_reg_err(err), .o_reg_addr(addr), .o_reg_wr(wr), .o_reg_rd(rd),
        .o_reg_wdata(wdata));
    task acc(input logic w, input logic [7:0] a, d);
        host.xfer(w, a, d, q, ok, er);
        `CHK("ack", 1'b1, ok)
        `CHK("err", a > 8'h01, er)
    endtask
    task pulse(input int b);
        ev[b] = 1'b1;
        repeat (4) @(negedge i_mclk);
        ev[b] = 1'b0;
        repeat (3) @(negedge i_mclk);
    endtask
    task end_sim;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end
    initial begin
        #1000000;
        n_mismatch++;
        end_sim;
    end
    initial begin
        {i_rst, reg_off, ev} = 10'h300;
        // Count rising edges so the time-zero clock step cannot shorten reset
        repeat (3) @(posedge i_mclk);
        @(negedge i_mclk);
        i_rst = 1'b0;
        `CHK("irq_rst", 1'b0, irq_n)
        acc(0, 8'h00, 8'h00);
        `CHK("flags_rst", 8'h80, q)
        `CHK("irq_clr", 1'b1, irq_n)
        foreach (bits[i]) begin
            bm = 8'h01 << bits[i];
            acc(1, 8'h01, bm);
            pulse(bits[i]);
            `CHK("irq_msk", 1'b1, irq_n)
            acc(0, 8'h00, 8'h00);
            `CHK("flag", bm, q)
            acc(1, 8'h01, 8'h7d & ~bm);
            pulse(bits[i]);
            `CHK("irq_set", 1'b0, irq_n)
            acc(0, 8'h00, 8'h00);
            `CHK("irq_rel", 1'b1, irq_n)
        end
        reg_off = 1'b0;
        acc(1, 8'h01, 8'h7d);
        ev[2] = 1'b1;
        repeat (4) @(negedge i_mclk);
        `CHK("int_rst", 1'b1, int_rst)
        pulse(2);
        `CHK("uv_mask", 8'h00, mask)
        `CHK("int_rst_rel", 1'b0, int_rst)
        acc(0, 8'h00, 8'h00);
        `CHK("uv_flags", 8'h80, q)
        for (int b = 1; b < 8; b += 6) begin
            acc(1, 8'h01, 8'h7d);
            pulse(b);
            `CHK("pwr_irq", 1'b0, irq_n)
            acc(0, 8'h00, 8'h00);
            `CHK("pwr_flag", 8'h80, q)
        end
        acc(1, 8'h01, 8'hff);
        acc(1, 8'h00, 8'hff);
        acc(0, 8'h01, 8'h00);
        `CHK("mask_rd", 8'h7d, q)
        acc(0, 8'h00, 8'h00);
        `CHK("flags_wr", 8'h00, q)
        acc(0, 8'h05, 8'h00);
        `CHK("unmapped", 8'h00, q)
        ev[0] = 1'b1;
        repeat (4) @(negedge i_mclk);
        acc(0, 8'h00, 8'h00);
        `CHK("temp_set", 8'h01, q)
        acc(0, 8'h00, 8'h00);
        `CHK("persist", 8'h01, q)
        pulse(0);
        acc(0, 8'h00, 8'h00);
        `CHK("latched", 8'h01, q)
        acc(0, 8'h00, 8'h00);
        `CHK("gone", 8'h00, q)
        end_sim;
    end
endmodule
